// File: hw/sere_pkg.sv
// Constants, types and helper functions shared by the serial EEPROM engine.
// Assumes a single 125 MHz system clock; all timing counts derive from it.
package sere_pkg;

    // ==========================================================
    // Addressing
    localparam logic [3:0] SERE_CTRL_CODE = 4'hA;
    localparam int SERE_PAGE_BYTES = 16;
    localparam int SERE_ARRAY_BYTES = 256;
    localparam logic [7:0] SERE_PTR_RST = 8'h00;

    // ==========================================================
    // Bit framing: eight data bits, then the acknowledge clock
    localparam logic [3:0] SERE_ACK_BIT = 4'h8;
    localparam logic [3:0] SERE_LAST_DATA_BIT = 4'h7;

    // ==========================================================
    // Write cycle time
    localparam int SERE_T_WR_MS = 1;
    localparam int SERE_CLK_KHZ = 125000;
    localparam int SERE_WR_CYCLES_DFLT = SERE_T_WR_MS * SERE_CLK_KHZ;
    localparam int SERE_WR_CNT_W = 17;

    // ==========================================================
    // Receive FIFO: 4-bit page offset plus data byte
    localparam int SERE_FIFO_DEPTH = 4;
    localparam int SERE_FIFO_WIDTH = 12;

    // ==========================================================
    // State encodings
    typedef enum logic [2:0] {
        SERE_ST_IDLE,
        SERE_ST_CTRL,
        SERE_ST_ADDR,
        SERE_ST_WDATA,
        SERE_ST_RDATA
    } sere_bus_st_t;

    typedef enum logic [1:0] {
        SERE_WC_IDLE,
        SERE_WC_DRAIN,
        SERE_WC_COPY,
        SERE_WC_TIME
    } sere_wc_st_t;

    // ==========================================================
    // Helpers
    function automatic logic sere_protected(input logic addr_msb, input logic wp);
        return addr_msb & wp;
    endfunction : sere_protected

    function automatic logic [7:0] sere_page_inc(input logic [7:0] ptr);
        return {ptr[7:4], ptr[3:0] + 4'h1};
    endfunction : sere_page_inc

endpackage : sere_pkg

// File: hw/sere_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes source and sink run on the same clock as the FIFO.
`timescale 1ns/100ps
`default_nettype none

module sere_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } sere_fifo_state_t;

    sere_fifo_state_t r;
    sere_fifo_state_t n;
    logic do_push;
    logic do_pop;

    assign in_ready_o = (r.cnt != CW'(DEPTH));
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o = r.mem[r.rd];
    assign do_push = in_valid_i & in_ready_o;
    assign do_pop = out_valid_o & out_ready_i;

    always_comb begin
        n = r;
        if (do_push) begin
            n.mem[r.wr] = in_data_i;
            n.wr = (r.wr == PW'(DEPTH - 1)) ? '0 : r.wr + PW'(1);
        end
        if (do_pop) begin
            n.rd = (r.rd == PW'(DEPTH - 1)) ? '0 : r.rd + PW'(1);
        end
        if (do_push && !do_pop) begin
            n.cnt = r.cnt + CW'(1);
        end else if (do_pop && !do_push) begin
            n.cnt = r.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : sere_fifo

`default_nettype wire

// File: hw/sere_engine.sv
// Command engine of a 256-byte two-wire serial EEPROM, bus slave side.
// Assumes SCL and SDA arrive from pins and are resynchronised here; the
// SDA wire level is resolved outside from sda_oe_o (open drain, drive low).
// Expects each SCL phase to last at least four system clocks.
//
// Notes on behaviour
// - Answer only matching control code and selects.
// - Release data line when master withholds acknowledge.
// - Accesses never leave this device's range.
// - Acknowledge write control byte on ninth clock.
// - Next byte loads the address pointer, acknowledged.
// - Stop after data starts write; no acknowledges.
// - Protected writes acknowledged, memory unchanged, full time.
// - Up to sixteen bytes buffered, committed on Stop.
// - Write increments low nibble only, wraps page.
// - Protect input high inhibits upper half writes.
// - Control bytes refused while write cycle runs.
// - Read bit set selects the three reads.
// - Current read sends word after last accessed.
// - Repeated Start keeps pointer, aborts write, reads.
// - Master acknowledge continues with next word.
// - Pointer increments per read, wraps FF to 00.
`timescale 1ns/100ps
`default_nettype none

module sere_engine
    import sere_pkg::*;
#(
    parameter int WR_CYCLES = SERE_WR_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Strap pins
    input wire logic [2:0] chip_select_inputs_i,
    input wire logic write_protect_i,
    // Status
    output logic busy_o,
    output logic [7:0] addr_ptr_o
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] wp_s;
        logic [1:0][2:0] cs_s;
        sere_bus_st_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic drv;
        logic sda_lvl;
        logic mack;
        logic first;
        logic got;
        logic [7:0] ptr;
        logic [3:0] page;
        logic push;
        logic [SERE_FIFO_WIDTH-1:0] push_data;
        sere_wc_st_t wst;
        logic [3:0] cidx;
        logic [SERE_WR_CNT_W-1:0] tmr;
        logic busy;
        logic [SERE_PAGE_BYTES-1:0][7:0] pbuf;
        logic [SERE_PAGE_BYTES-1:0] pmask;
        logic [SERE_ARRAY_BYTES-1:0][7:0] mem;
    } sere_state_t;

    sere_state_t r;
    sere_state_t n;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_in;
    logic ctrl_match;
    logic code_hit;
    logic sel_hit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [SERE_FIFO_WIDTH-1:0] fifo_out_data;

    // ==========================================================
    // Bus condition detection on the resynchronised second stages
    // Start and Stop are SDA edges while SCL stays high
    assign sda_in = r.sda_s[1];
    assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
    assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
    assign start_det = r.scl_s[1] & r.scl_s[2] & r.sda_s[2] & ~r.sda_s[1];
    assign stop_det = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[2] & r.sda_s[1];

    // Busy blocks every control byte, so polling sees no acknowledge
    assign code_hit = (r.sh[7:4] == SERE_CTRL_CODE);
    assign sel_hit = (r.sh[3:1] == r.cs_s[1]);
    assign ctrl_match = code_hit && sel_hit && !r.busy;

    // Drain stalls while the page buffer is being copied into the array
    assign fifo_out_ready = (r.wst == SERE_WC_IDLE) || (r.wst == SERE_WC_DRAIN);

    // ==========================================================
    // Receive FIFO between the serial front end and the page buffer
    // Four entries are ample: a byte arrives only every nine bus clocks
    sere_fifo #(
        .WIDTH(SERE_FIFO_WIDTH),
        .DEPTH(SERE_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(r.push),
        .in_data_i(r.push_data),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(fifo_out_ready)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        n = r;
        n.push = 1'b0;
        n.scl_s = {r.scl_s[1:0], scl_i};
        n.sda_s = {r.sda_s[1:0], sda_i};
        n.wp_s = {r.wp_s[0], write_protect_i};
        n.cs_s = {r.cs_s[0], chip_select_inputs_i};
        // The pin is open drain: only the enable ever changes the wire
        n.sda_lvl = 1'b0;

        // Serial front end
        if (start_det) begin
            // A repeated Start leaves the pointer untouched and drops the write
            n.st = SERE_ST_CTRL;
            // Every Start ends with a clock fall that carries no bit; parking
            // the counter past the acknowledge slot lets that fall clear it
            n.bitcnt = 4'hF;
            n.drv = 1'b0;
            n.got = 1'b0;
        end else if (stop_det) begin
            if (r.st == SERE_ST_WDATA && r.got) begin
                n.wst = SERE_WC_DRAIN;
                n.busy = 1'b1;
                n.tmr = '0;
            end
            n.st = SERE_ST_IDLE;
            n.drv = 1'b0;
            n.got = 1'b0;
        end else if (r.st != SERE_ST_IDLE) begin
            if (scl_rise) begin
                if (r.bitcnt < SERE_ACK_BIT) begin
                    n.sh = {r.sh[6:0], sda_in};
                end else begin
                    n.mack = ~sda_in;
                end
            end else if (scl_fall) begin
                if (r.bitcnt < SERE_LAST_DATA_BIT) begin
                    n.bitcnt = r.bitcnt + 4'h1;
                    if (r.st == SERE_ST_RDATA) begin
                        n.tx = {r.tx[6:0], 1'b0};
                        n.drv = ~r.tx[6];
                    end
                end else if (r.bitcnt == SERE_LAST_DATA_BIT) begin
                    // Byte complete: decide the acknowledge for the ninth clock
                    n.bitcnt = SERE_ACK_BIT;
                    n.drv = 1'b0;
                    unique case (r.st)
                        SERE_ST_CTRL: begin
                            if (ctrl_match) begin
                                n.drv = 1'b1;
                                if (r.sh[0]) begin
                                    n.st = SERE_ST_RDATA;
                                    n.first = 1'b1;
                                end else begin
                                    n.st = SERE_ST_ADDR;
                                end
                            end else begin
                                n.st = SERE_ST_IDLE;
                            end
                        end
                        SERE_ST_ADDR: begin
                            n.drv = 1'b1;
                            n.ptr = r.sh;
                            n.page = r.sh[7:4];
                            n.pmask = '0;
                            n.st = SERE_ST_WDATA;
                        end
                        SERE_ST_WDATA: begin
                            // A full FIFO cannot take the byte, so it is refused
                            if (fifo_in_ready) begin
                                n.drv = 1'b1;
                                n.push = 1'b1;
                                n.push_data = {r.ptr[3:0], r.sh};
                                // Offset wraps inside the page, so an overrun rewrites earlier bytes
                                n.ptr = sere_page_inc(r.ptr);
                                n.got = 1'b1;
                            end
                        end
                        SERE_ST_RDATA: begin
                            n.first = 1'b0;
                        end
                        SERE_ST_IDLE: begin
                            n.st = SERE_ST_IDLE;
                        end
                        default: begin
                            // An illegal code falls back to idle until the next Start
                            n.st = SERE_ST_IDLE;
                        end
                    endcase
                end else begin
                    // End of the acknowledge clock
                    n.bitcnt = 4'h0;
                    n.drv = 1'b0;
                    if (r.st == SERE_ST_RDATA) begin
                        if (r.first || r.mack) begin
                            n.tx = r.mem[r.ptr];
                            n.drv = ~r.mem[r.ptr][7];
                            n.ptr = r.ptr + 8'h01;
                            n.first = 1'b0;
                        end else begin
                            n.st = SERE_ST_IDLE;
                        end
                    end
                end
            end
        end

        // Page buffer fill from the FIFO
        if (fifo_out_valid && fifo_out_ready) begin
            // Later bytes at the same offset replace earlier ones
            n.pbuf[fifo_out_data[11:8]] = fifo_out_data[7:0];
            n.pmask[fifo_out_data[11:8]] = 1'b1;
        end

        // Self-timed write cycle; the timer runs from the Stop, so drain and
        // copy fall inside it and WR_CYCLES must cover them (at least 18, plus one per byte still in the FIFO),
        // otherwise busy outlasts the programmed time
        if (r.wst != SERE_WC_IDLE) begin
            n.tmr = r.tmr + SERE_WR_CNT_W'(1);
        end
        unique case (r.wst)
            SERE_WC_IDLE: begin
                n.cidx = 4'h0;
            end
            SERE_WC_DRAIN: begin
                if (!fifo_out_valid) begin
                    n.wst = SERE_WC_COPY;
                    n.cidx = 4'h0;
                end
            end
            SERE_WC_COPY: begin
                // Protected bytes are skipped but the full time still runs
                if (r.pmask[r.cidx] && !sere_protected(r.page[3], r.wp_s[1])) begin
                    n.mem[{r.page, r.cidx}] = r.pbuf[r.cidx];
                end
                n.cidx = r.cidx + 4'h1;
                if (r.cidx == 4'hF) begin
                    n.wst = SERE_WC_TIME;
                end
            end
            SERE_WC_TIME: begin
                if (r.tmr >= SERE_WR_CNT_W'(WR_CYCLES - 1)) begin
                    n.wst = SERE_WC_IDLE;
                    n.busy = 1'b0;
                    n.pmask = '0;
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r <= '0;
            // Both bus lines idle high; starting the synchronisers there
            // avoids a false clock edge right after reset
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign sda_o = r.sda_lvl;
    assign sda_oe_o = r.drv;
    assign busy_o = r.busy;
    assign addr_ptr_o = r.ptr;

endmodule : sere_engine

`default_nettype wire

// File: tb/sere_master.sv
// Two-wire bus master model that drives the engine's clock and data pins.
// Assumes the bench resolves the open-drain data wire and feeds it back here.
`timescale 1ns/100ps
`default_nettype none

module sere_master (
    // Clock
    input wire logic clk_i,
    // Bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge clk_i);
    endtask : hw

    // ====================================
    // Bit level, eight system clocks a bit
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = ~b;
        hw(2);
        scl_o = 1'b1;
        hw(4);
        r = sda_i;
        scl_o = 1'b0;
        hw(2);
    endtask : bit_x

    // Longer lead-in lets a held acknowledge clear before the clock rises
    task automatic start();
        sda_low_o = 1'b0;
        hw(4);
        scl_o = 1'b1;
        hw(4);
        sda_low_o = 1'b1;
        hw(4);
        scl_o = 1'b0;
        hw(2);
    endtask : start

    task automatic stop();
        sda_low_o = 1'b1;
        hw(4);
        scl_o = 1'b1;
        hw(4);
        sda_low_o = 1'b0;
        hw(6);
    endtask : stop

    // ====================================
    // Byte level, most significant bit first
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(~mack, r);
        ack = ~r;
    endtask : xfer
endmodule : sere_master
`default_nettype wire

// File: tb/sere_engine_monitor.sv
// Checker on the engine's pins and status ports.
// Assumes one clock domain and the open-drain data wire resolved outside.
`timescale 1ns/100ps
`default_nettype none

module sere_engine_monitor #(
    parameter int WR_CYCLES = 200
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // Straps and status
    input wire logic [2:0] chip_select_inputs_i,
    input wire logic write_protect_i,
    input wire logic busy_o,
    input wire logic [7:0] addr_ptr_o
);
    // ====================================
    // Busy length counter
    logic [31:0] busy_cnt_r;
    always_ff @(posedge clk_i) begin
        if (reset_i || !busy_o) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end
    end

    // ====================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_hold;
        sda_oe_o [*8];
    endsequence
    property p_open_drain; sda_oe_o |-> !sda_o; endproperty
    property p_quiet_busy; busy_o && $past(busy_o) |-> !sda_oe_o; endproperty
    property p_ptr_frozen; busy_o && $past(busy_o) |-> $stable(addr_ptr_o); endproperty
    property p_busy_len; $fell(busy_o) |-> busy_cnt_r == WR_CYCLES; endproperty
    property p_busy_max; busy_cnt_r <= WR_CYCLES; endproperty
    property p_busy_after_stop; $rose(busy_o) |-> $past(scl_i, 6) && sda_i; endproperty
    property p_oe_scl_low; $changed(sda_oe_o) |-> !$past(scl_i, 3); endproperty
    property p_hold; $rose(sda_oe_o) |-> s_hold; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    a_quiet_busy: assert property (p_quiet_busy) else $error("drive during write cycle");
    a_ptr_frozen: assert property (p_ptr_frozen) else $error("pointer moved while busy");
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
    a_busy_after_stop: assert property (p_busy_after_stop) else $error("write cycle without stop");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
    a_hold: assert property (p_hold) else $error("low pulse shorter than a bit");
endmodule : sere_engine_monitor

bind sere_engine sere_engine_monitor #(.WR_CYCLES(WR_CYCLES)) i_sere_engine_monitor (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .chip_select_inputs_i(chip_select_inputs_i), .write_protect_i(write_protect_i), .busy_o(busy_o),
    .addr_ptr_o(addr_ptr_o));
`default_nettype wire

// File: tb/sere_engine_test.sv
// Self-checking bench for the serial EEPROM engine.
// Assumes the master model in sere_master and a pull-up on the data wire.
`timescale 1ns/100ps
`default_nettype none

module sere_engine_test;
    import sere_pkg::*;
    localparam int WRC = 200;
    localparam logic [7:0] CW = {SERE_CTRL_CODE, 3'h5, 1'b0};
    logic clk_i;
    logic reset_i = 1'b1;
    logic wp = 1'b0;
    logic scl, m_low, sda, sda_oe_o, busy_o, a;
    logic [7:0] addr_ptr_o, q;
    logic [7:0] e[$];
    int num_errors = 0;
    int tests_run = 0;
    assign sda = ~(m_low | sda_oe_o);

    sere_engine #(.WR_CYCLES(WRC)) i_sere_engine (.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(sda_oe_o), .chip_select_inputs_i(3'h5), .write_protect_i(wp), .busy_o(busy_o),
        .addr_ptr_o(addr_ptr_o));
    sere_master i_sere_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ====================================
    // Checking and closing
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
        tests_run++;
        if (s !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // ====================================
    // Bus sequences
    task automatic sb(input logic [7:0] d, input logic m, input logic x);
        i_sere_master.xfer(d, m, q, a);
        chk("ack", {7'h00, a}, {7'h00, x});
    endtask : sb

    // Write the bytes in e from ad, then poll until the write cycle ends
    task automatic wr(input logic [7:0] ad, input logic [7:0] ptr);
        i_sere_master.start();
        sb(CW, 1'b0, 1'b1);
        sb(ad, 1'b0, 1'b1);
        foreach (e[i]) sb(e[i], 1'b0, 1'b1);
        chk("ptr", addr_ptr_o, ptr);
        i_sere_master.stop();
        chk("busy", {7'h00, busy_o}, 8'h01);
        a = 1'b0;
        for (int n = 0; n < 40 && !a; n++) begin
            i_sere_master.start();
            i_sere_master.xfer(CW, 1'b0, q, a);
            if (n == 0) chk("poll", {7'h00, a}, 8'h00);
        end
        i_sere_master.stop();
        chk("idle", {6'h00, a, busy_o}, 8'h02);
    endtask : wr

    // Read the bytes expected in e, optionally setting the pointer first
    task automatic rd(input logic set, input logic [7:0] ad);
        if (set) begin
            i_sere_master.start();
            sb(CW, 1'b0, 1'b1);
            sb(ad, 1'b0, 1'b1);
        end
        i_sere_master.start();
        sb(CW | 8'h01, 1'b0, 1'b1);
        foreach (e[i]) begin
            sb(8'hFF, i < e.size() - 1, i < e.size() - 1);
            chk("rdata", q, e[i]);
        end
        i_sere_master.stop();
        chk("busy", {7'h00, busy_o}, 8'h00);
    endtask : rd

    // ====================================
    // Tests
    initial begin
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("ptr", addr_ptr_o, SERE_PTR_RST);
        for (int k = 0; k < 2; k++) begin
            i_sere_master.start();
            sb(k ? CW ^ 8'h10 : CW ^ 8'h04, 1'b0, 1'b0);
            i_sere_master.stop();
            chk("busy", {7'h00, busy_o}, 8'h00);
        end
        e = '{8'h5A};
        wr(8'hFF, 8'hF0);
        e = {};
        for (int k = 0; k < 18; k++) e.push_back(8'hC0 + k[7:0]);
        wr(8'h7E, 8'h70);
        wp = 1'b1;
        e = '{8'h11};
        wr(8'h85, 8'h86);
        wp = 1'b0;
        // Overrun wrapped the last two bytes onto offsets E and F
        e = {};
        for (int k = 0; k < 15; k++) e.push_back(8'hC2 + k[7:0]);
        rd(1'b1, 8'h70);
        chk("ptr", addr_ptr_o, 8'h7F);
        e = '{8'hD1};
        rd(1'b0, 8'h00);
        e = '{8'h5A, 8'h00};
        rd(1'b1, 8'hFF);
        chk("ptr", addr_ptr_o, 8'h01);
        e = '{8'h00};
        rd(1'b1, 8'h85);
        summarize();
    end

    // Whole run is near 5k cycles; this leaves ample margin
    initial begin
        #500000;
        num_errors++;
        summarize();
    end
endmodule : sere_engine_test
`default_nettype wire
